// ==== rtl/tfi_hb_monitor.sv ====
// tfi_hb_monitor: heartbeat average band check.
// assumes synced i_hb, one-cycle i_tick.
`timescale 1ns/1ps
module tfi_hb_monitor import tfi_pkg::*; (
    input wire logic i_clk, // logic clock
    input wire logic i_rstn, // sync reset, active low
    input wire logic i_tick, // averaging step enable
    input wire logic i_hb, // returned heartbeat level
    output logic o_ok // average inside both thresholds
);
    logic [HB_ACC_W-1:0] acc_reg;
    logic [HB_ACC_W-1:0] acc_next;

    // leaky integrator: settles near 256, mid-band, for a 50 percent square wave
    always_comb
    begin
        acc_next = acc_reg - (acc_reg >> HB_SHIFT);
        if (i_hb)
            acc_next = acc_next + HB_ADD;
    end

    // starts at zero so health is false until the average climbs
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
            acc_reg <= '0;
        else if (i_tick)
            acc_reg <= acc_next;
    end

    // a stuck high or low return drifts out of the band
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
            o_ok <= 1'b0;
        else
            o_ok <= (acc_reg > HB_THR_LO) && (acc_reg < HB_THR_HI);
    end
endmodule // tfi_hb_monitor

// ==== rtl/tfi_interlock.sv ====
// tfi_interlock: fault latches, arming, plc.
// assumes apb on i_clk; pins asynchronous.
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module tfi_interlock import tfi_pkg::*; #(
    parameter int P_HB_HALF = HB_HALF_CYC,
    parameter int P_HB_TICK = HB_TICK_CYC,
    parameter int P_MS = MS_CYC,
    parameter int P_WDOG = WDOG_CYC
)(
    input wire logic i_clk, // 40 MHz logic clock
    input wire logic i_rstn, // sync reset, active low
    input wire logic i_psel, // apb select
    input wire logic i_penable, // apb enable
    input wire logic i_pwrite, // apb write
    input wire logic [7:0] i_paddr, // apb byte address
    input wire logic [31:0] i_pwdata, // apb write data
    output logic [31:0] o_prdata, // apb read data
    output logic o_pready, // apb ready
    output logic o_pslverr, // apb error
    input wire logic [3:0] i_ct_trip, // overcurrent comparators
    input wire logic [3:0] i_link_lost, // link module comms lost
    input wire logic [3:0] i_temp_trip, // collector_temp_model trips
    input wire logic [7:0] i_soft_src, // arc and reflected power
    input wire logic i_rail_fail, // local supply rail failed
    input wire logic i_ctrl_ok, // control-ok fibre, high=ok
    input wire logic i_wg_inhibit, // waveguide switch inhibit
    input wire logic i_fault_bypass, // calibration bypass
    input wire logic i_acs_hv_req, // amplifier_control_system hv on
    input wire logic i_acs_rf_req, // amplifier_control_system rf on
    input wire logic i_hv_en_echo, // sync box hv enabled
    input wire logic i_rf_on_echo, // sync box rf on
    input wire logic [15:0] i_plc_ctrl, // plc control bits
    input wire logic i_pb_reset, // front-panel pushbutton
    input wire logic i_shot_start, // shot_start_pulse
    input wire logic i_shot_clock, // shot_clock
    input wire logic i_hb_return, // heartbeat from last stage
    output logic o_heartbeat, // heartbeat into chain
    output logic o_hb_ok, // heartbeat health fibre
    output logic o_hv_enable_req, // to system_sync_box
    output logic o_hv_on_req, // to system_sync_box
    output logic o_rf_group_req, // to system_sync_box
    output logic [3:0] o_pin_sw, // pin diode switches a-d
    output logic o_rf_permissive, // rf_permissive
    output logic [31:0] o_plc_status_lo, // 32-bit status link
    output logic [15:0] o_plc_status_hi, // 16-bit status link
    output logic o_event_start, // event timer start pulse
    output logic o_shot_start_echo, // front-panel repeat
    output logic o_shot_clock_echo, // front-panel repeat
    output logic [1:0] o_led1, // tfi_led_e code
    output logic [1:0] o_led2, // tfi_led_e code
    output logic [1:0] o_led3, // tfi_led_e code
    output logic [1:0] o_led4 // tfi_led_e code
);
    // latch update: set beats a simultaneous clear
    function automatic logic [13:0] latch_upd(input logic [13:0] q,
        input logic [13:0] set, input logic clr);
        latch_upd = set | (q & ~{14{clr}});
    endfunction

    logic [47:0] syn;
    logic [3:0] ct_s, link_s, temp_s, plc_rf;
    logic [7:0] soft_s;
    logic [15:0] plc_s;
    logic rail_s, ctrlok_s, wg_s, byp_s, acshv_s, acsrf_s, hven_s, rfon_s;
    logic pb_s, start_s, sclk_s, hb_s;

    // all pin levels pass two flops before any logic
    tfi_sync #(.W(48)) u_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_d({i_ct_trip, i_link_lost, i_temp_trip, i_soft_src,
            i_rail_fail, i_ctrl_ok, i_wg_inhibit, i_fault_bypass,
            i_acs_hv_req, i_acs_rf_req, i_hv_en_echo, i_rf_on_echo,
            i_plc_ctrl, i_pb_reset, i_shot_start, i_shot_clock,
            i_hb_return}),
        .o_q(syn)
    );

    assign {ct_s, link_s, temp_s, soft_s} = syn[47:28];
    assign {rail_s, ctrlok_s, wg_s, byp_s} = syn[27:24];
    assign {acshv_s, acsrf_s, hven_s, rfon_s} = syn[23:20];
    assign plc_s = syn[19:4];
    assign {pb_s, start_s, sclk_s, hb_s} = syn[3:0];
    assign plc_rf = plc_s[PLC_RF_A+3:PLC_RF_A];

    // dividers: heartbeat half period, averaging tick, 1 ms tick
    logic [17:0] hb_cnt_reg;
    logic [14:0] tick_cnt_reg;
    logic [15:0] ms_cnt_reg;
    logic hb_tick, ms_tick;
    assign hb_tick = (tick_cnt_reg == 15'(P_HB_TICK - 1));
    assign ms_tick = (ms_cnt_reg == 16'(P_MS - 1));

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            hb_cnt_reg <= '0;
            o_heartbeat <= 1'b0;
        end
        else if (hb_cnt_reg == 18'(P_HB_HALF - 1))
        begin
            hb_cnt_reg <= '0;
            o_heartbeat <= ~o_heartbeat;
        end
        else
            hb_cnt_reg <= hb_cnt_reg + 18'h00001;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || hb_tick)
            tick_cnt_reg <= '0;
        else
            tick_cnt_reg <= tick_cnt_reg + 15'h0001;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || ms_tick)
            ms_cnt_reg <= '0;
        else
            ms_cnt_reg <= ms_cnt_reg + 16'h0001;
    end

    // health checked on the chain's return, not our own output
    tfi_hb_monitor u_hb (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_tick(hb_tick),
        .i_hb(hb_s),
        .o_ok(o_hb_ok)
    );

    // apb decode; registers answer with no wait states
    logic access, wr_en, err_reg, por_reg, host_rst_reg, arm_cmd;
    logic [31:0] rd_mux;
    logic bad;
    logic [15:0] soft_dly_reg, shot_tmo_reg;
    logic [7:0] retry_lim_reg, attempts_reg;
    logic [25:0] wdog_cnt_reg;
    tfi_arm_e arm_state;
    logic armed;
    assign armed = (arm_state != ST_IDLE);
    assign access = i_psel && i_penable;
    assign wr_en = access && i_pwrite && !err_reg;
    assign arm_cmd = wr_en && (i_paddr == ADDR_CTRL) && i_pwdata[CTRL_ARM];
    assign o_pready = 1'b1;
    assign o_pslverr = access && err_reg;

    // while armed only status reads and ctrl writes are served
    always_comb
    begin
        rd_mux = '0;
        bad = 1'b0;
        case (i_paddr)
            ADDR_CTRL: rd_mux = {31'h0, armed};
            ADDR_STAT_LO: rd_mux = o_plc_status_lo;
            ADDR_STAT_HI: rd_mux = {16'h0, o_plc_status_hi};
            ADDR_SOFT_DLY: rd_mux = {16'h0, soft_dly_reg};
            ADDR_RETRY_LIM: rd_mux = {24'h0, retry_lim_reg};
            ADDR_SHOT_TMO: rd_mux = {16'h0, shot_tmo_reg};
            default: bad = 1'b1;
        endcase
        if (armed && !((i_paddr == ADDR_CTRL) && i_pwrite)
            && !(!i_pwrite && ((i_paddr == ADDR_STAT_LO)
            || (i_paddr == ADDR_STAT_HI))))
            bad = 1'b1;
    end

    // read data and error are captured in the setup cycle
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            o_prdata <= '0;
            err_reg <= 1'b0;
        end
        else if (i_psel && !i_penable)
        begin
            o_prdata <= i_pwrite ? 32'h0 : rd_mux;
            err_reg <= bad;
        end
    end

    // programmable delays and limits
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            soft_dly_reg <= SOFT_DLY_RST;
            retry_lim_reg <= RETRY_LIM_RST;
            shot_tmo_reg <= SHOT_TMO_RST;
        end
        else if (wr_en)
        begin
            if (i_paddr == ADDR_SOFT_DLY)
                soft_dly_reg <= i_pwdata[15:0];
            if (i_paddr == ADDR_RETRY_LIM)
                retry_lim_reg <= i_pwdata[7:0];
            if (i_paddr == ADDR_SHOT_TMO)
                shot_tmo_reg <= i_pwdata[15:0];
        end
    end

    // power-on one-shot and host reset pulse
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            por_reg <= 1'b1;
            host_rst_reg <= 1'b0;
        end
        else
        begin
            por_reg <= 1'b0;
            host_rst_reg <= wr_en && (i_paddr == ADDR_CTRL)
                && i_pwdata[CTRL_RESET];
        end
    end

    // sources are indistinguishable once ORed
    logic gen_rst;
    assign gen_rst = host_rst_reg | plc_s[PLC_RESET] | pb_s | por_reg;

    // watchdog: a host feed restarts the count; expiry holds a fault
    logic wdog_exp;
    assign wdog_exp = (wdog_cnt_reg == 26'(P_WDOG - 1));
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || (wr_en && (i_paddr == ADDR_CTRL)
            && i_pwdata[CTRL_FEED]))
            wdog_cnt_reg <= '0;
        else if (!wdog_exp)
            wdog_cnt_reg <= wdog_cnt_reg + 26'h0000001;
    end

    // hard latches: ct, link, temperature model, rail, watchdog
    logic [13:0] hard_reg, hard_set;
    logic [7:0] soft_reg;
    logic ctrl_flt_reg, soft_rst_reg, hard_any, soft_any, limit_hit;
    assign hard_set = {ct_s, link_s,
        temp_s & ~{4{plc_s[PLC_SYNC_OVR]}},
        rail_s, wdog_exp};
    assign hard_any = |hard_reg;
    assign soft_any = |soft_reg;
    assign limit_hit = (attempts_reg >= retry_lim_reg);

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
            hard_reg <= '0;
        else
            hard_reg <= latch_upd(hard_reg, hard_set, gen_rst);
    end

    // control-ok loss is latched but only stops hv on and rf on
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
            ctrl_flt_reg <= 1'b0;
        else
            ctrl_flt_reg <= !ctrlok_s || (ctrl_flt_reg && !gen_rst);
    end

    // soft latches also clear on the automatic soft reset
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
            soft_reg <= '0;
        else
            soft_reg <= soft_s
                | (soft_reg & ~{8{gen_rst | soft_rst_reg}});
    end

    // retry delay in ms; stops once the attempt limit is reached
    logic [15:0] dly_cnt_reg;
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || gen_rst || !soft_any || limit_hit || soft_rst_reg)
        begin
            dly_cnt_reg <= '0;
            soft_rst_reg <= 1'b0;
        end
        else
        begin
            if (ms_tick)
                dly_cnt_reg <= dly_cnt_reg + 16'h0001;
            soft_rst_reg <= (dly_cnt_reg >= soft_dly_reg);
        end
    end

    // attempt count doubles as the escalation latch; reset clears it
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || gen_rst)
            attempts_reg <= '0;
        else if (soft_rst_reg && !limit_hit)
            attempts_reg <= attempts_reg + 8'h01;
    end

    // arming: host arms, shot start edges run and end the shot
    logic start_d_reg;
    logic [15:0] tmo_cnt_reg;
    logic tmo_hit, start_rise, start_fall;
    assign start_rise = start_s && !start_d_reg;
    assign start_fall = !start_s && start_d_reg;
    assign tmo_hit = (tmo_cnt_reg >= shot_tmo_reg);

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            arm_state <= ST_IDLE;
            start_d_reg <= 1'b0;
            o_event_start <= 1'b0;
        end
        else
        begin
            start_d_reg <= start_s;
            o_event_start <= 1'b0;
            case (arm_state)
                ST_IDLE:
                    if (arm_cmd)
                        arm_state <= ST_ARMED;
                ST_ARMED:
                    if (tmo_hit)
                        arm_state <= ST_IDLE;
                    else if (start_rise)
                    begin
                        arm_state <= ST_SHOT;
                        o_event_start <= 1'b1;
                    end
                ST_SHOT:
                    if (start_fall || tmo_hit)
                        arm_state <= ST_IDLE;
                default: arm_state <= ST_IDLE;
            endcase
        end
    end

    // same timeout covers a missing start and a start stuck high
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || !armed || start_rise)
            tmo_cnt_reg <= '0;
        else if (ms_tick && !tmo_hit)
            tmo_cnt_reg <= tmo_cnt_reg + 16'h0001;
    end

    // permissive and requests; registered so outputs are glitch-free
    logic rf_perm;
    assign rf_perm = armed && !gen_rst && !soft_rst_reg && !soft_any
        && !hard_any && !ctrl_flt_reg && !limit_hit
        && !wg_s;

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            o_hv_enable_req <= 1'b0;
            o_hv_on_req <= 1'b0;
            o_rf_group_req <= 1'b0;
            o_pin_sw <= '0;
            o_rf_permissive <= 1'b0;
        end
        else
        begin
            o_rf_permissive <= rf_perm;
            // hv enable ignores armed, limit and control-ok
            o_hv_enable_req <= plc_s[PLC_HV_EN] && !hard_any && !byp_s
                && o_hb_ok;
            o_hv_on_req <= acshv_s && armed && !ctrl_flt_reg && !limit_hit
                && !gen_rst && hven_s && !hard_any && !byp_s
                && o_hb_ok;
            o_rf_group_req <= acsrf_s && rf_perm && !byp_s
                && o_hb_ok;
            // bypass lets plc bits drive pins for calibration, gated only by heartbeat health
            o_pin_sw <= plc_rf & {4{o_hb_ok && (byp_s
                || (rfon_s && rf_perm))}};
        end
    end

    // status words, shared by the plc links and host queries
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            o_plc_status_lo <= '0;
            o_plc_status_hi <= '0;
        end
        else
        begin
            o_plc_status_lo <= {soft_reg, hard_reg, ctrl_flt_reg,
                limit_hit, o_hb_ok, armed, o_hv_enable_req, o_hv_on_req,
                rf_perm, o_rf_group_req, byp_s, soft_any};
            o_plc_status_hi <= {o_pin_sw, attempts_reg, hven_s, rfon_s,
                hard_any, start_s};
        end
    end

    // front-panel repeats and leds; red has priority on leds 3 and 4
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            o_shot_start_echo <= 1'b0;
            o_shot_clock_echo <= 1'b0;
            o_led1 <= LED_OFF;
            o_led2 <= LED_OFF;
            o_led3 <= LED_OFF;
            o_led4 <= LED_OFF;
        end
        else
        begin
            o_shot_start_echo <= start_s;
            o_shot_clock_echo <= sclk_s;
            o_led1 <= armed ? LED_GREEN : LED_OFF;
            o_led2 <= hven_s ? LED_GREEN : LED_OFF;
            o_led3 <= hard_any ? LED_RED
                : (o_hv_on_req ? LED_GREEN : LED_OFF);
            o_led4 <= soft_any ? LED_RED
                : ((rfon_s && rf_perm) ? LED_GREEN : LED_OFF);
        end
    end
endmodule // tfi_interlock

// ==== rtl/tfi_pkg.sv ====
// tfi_pkg: interlock constants.
// assumes one 40 MHz clock, sync low reset.
//
// How it works
// - 100 Hz heartbeat through the chain.
// - heartbeat out of band stops hv and rf.
// - heartbeat health on its own pin.
// - watchdog unfed 1 s stops hv and rf.
// - soft fault drops rf and pin switches.
// - delayed soft reset clears gone causes.
// - soft reset attempts hit a limit.
// - limit or control-ok loss: hv enable kept.
// - ct, link, rail, watchdog latch hard.
// - hard fault drops hv enable and hv on.
// - temperature model trip is hard.
// - plc: 32 plus 16 status out, 16 in.
// - plc bits: hv en, rf a-d, reset, override.
// - same 48 status bits to plc and host.
// - led1 armed, led2 hv enabled, never red.
// - led3 hv on or hard; led4 rf on or soft.
// - hv on and rf on need armed.
// - host arms; start rise times, fall disarms.
// - missing or stuck start times out.
// - armed refuses most host commands.
// - general reset ORs four sources.
// - shot clock and start echoed on panel.
// - rf permissive ANDs armed and no faults.
package tfi_pkg;
    // timing counts
    localparam int CLK_HZ = 40_000_000;
    localparam int HB_FREQ_HZ = 100;
    localparam int HB_HALF_CYC = CLK_HZ / (2 * HB_FREQ_HZ);
    localparam int HB_TICKS_PER_HALF = 8;
    localparam int HB_TICK_CYC = HB_HALF_CYC / HB_TICKS_PER_HALF;
    localparam int MS_CYC = CLK_HZ / 1000;
    localparam int WDOG_TIMEOUT_MS = 1000;
    localparam int WDOG_CYC = MS_CYC * WDOG_TIMEOUT_MS;

    // heartbeat averager: acc += add when high, minus acc >> shift
    localparam int HB_ACC_W = 10;
    localparam logic [9:0] HB_ADD = 10'h008;
    localparam int HB_SHIFT = 6;
    localparam logic [9:0] HB_THR_LO = 10'h080;
    localparam logic [9:0] HB_THR_HI = 10'h180;

    // apb byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT_LO = 8'h04;
    localparam logic [7:0] ADDR_STAT_HI = 8'h08;
    localparam logic [7:0] ADDR_SOFT_DLY = 8'h0c;
    localparam logic [7:0] ADDR_RETRY_LIM = 8'h10;
    localparam logic [7:0] ADDR_SHOT_TMO = 8'h14;

    // ctrl write bits (self-clearing commands)
    localparam int CTRL_ARM = 0;
    localparam int CTRL_RESET = 1;
    localparam int CTRL_FEED = 2;

    // reset values of programmable registers (ms, count, ms)
    localparam logic [15:0] SOFT_DLY_RST = 16'h0032;
    localparam logic [7:0] RETRY_LIM_RST = 8'h03;
    localparam logic [15:0] SHOT_TMO_RST = 16'h2710;

    // plc control channel positions
    localparam int PLC_HV_EN = 0;
    localparam int PLC_RF_A = 1;
    localparam int PLC_RESET = 5;
    localparam int PLC_SYNC_OVR = 6;

    typedef enum logic [1:0] {LED_OFF, LED_GREEN, LED_RED} tfi_led_e;
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_SHOT} tfi_arm_e;
endpackage

// ==== rtl/tfi_sync.sv ====
// tfi_sync: two-flop pin synchroniser.
// assumes independent levels per bit.
`timescale 1ns/1ps
module tfi_sync #(
    parameter int W = 1
)(
    input wire logic i_clk, // logic clock
    input wire logic i_rstn, // sync reset, active low
    input wire logic [W-1:0] i_d, // asynchronous levels
    output logic [W-1:0] o_q // synchronised levels
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            meta_reg <= '0;
            o_q <= '0;
        end
        else
        begin
            meta_reg <= i_d;
            o_q <= meta_reg;
        end
    end
endmodule // tfi_sync

// ==== test/tb_top.sv ====
// tb_top: directed interlock scenarios.
// assumes short timing, plant loop-back.
`timescale 1ns/1ps
module tb_top import tfi_pkg::*; ;
    logic i_clk = 1'b0, i_rstn = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
    logic i_pwrite = 1'b0, i_rail_fail = 1'b0, i_ctrl_ok = 1'b1;
    logic i_wg_inhibit = 1'b0, i_fault_bypass = 1'b0, i_acs_hv_req = 1'b0;
    logic i_acs_rf_req = 1'b0, i_pb_reset = 1'b0, i_shot_start = 1'b0;
    logic i_shot_clock = 1'b0, i_hb_return, i_hv_en_echo, i_rf_on_echo;
    logic [7:0] i_paddr = 8'h00, i_soft_src = 8'h00;
    logic [3:0] i_ct_trip = 4'h0, i_link_lost = 4'h0, i_temp_trip = 4'h0;
    logic [15:0] i_plc_ctrl = 16'h0000, o_plc_status_hi;
    logic [31:0] i_pwdata = 32'h0, o_prdata, o_plc_status_lo, rd;
    logic o_pready, o_pslverr, o_heartbeat, o_hb_ok, o_hv_enable_req, err;
    logic o_hv_on_req, o_rf_group_req, o_rf_permissive, o_event_start;
    logic o_shot_start_echo, o_shot_clock_echo;
    logic [3:0] o_pin_sw;
    logic [1:0] o_led1, o_led2, o_led3, o_led4;
    int miscompares = 0, checks = 0, cyc = 0;
    int sh[4] = '{0, 5, 8, 12};
    // short counts keep heartbeat and ms timing within a few cycles
    tfi_interlock #(.P_HB_HALF(40), .P_HB_TICK(5), .P_MS(10),
        .P_WDOG(80000)) dut_u (.*);
    tfi_plant_model plant_u (.i_clk(i_clk), .i_heartbeat(o_heartbeat),
        .i_hv_enable_req(o_hv_enable_req), .i_rf_group_req(o_rf_group_req),
        .o_hb_return(i_hb_return), .o_hv_en_echo(i_hv_en_echo),
        .o_rf_on_echo(i_rf_on_echo));
    initial forever #12.5 i_clk = ~i_clk;
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex,
        input logic [31:0] got);
        checks++;
        if (got !== ex)
        begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", nm, ex, got);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        @(posedge i_clk);
        while (o_pready !== 1'b1)
            @(posedge i_clk);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic t_regs();
        apb(0, ADDR_SOFT_DLY, 0);
        chk("soft delay", {16'h0, SOFT_DLY_RST}, rd);
        apb(0, ADDR_RETRY_LIM, 0);
        chk("retry limit", {24'h0, RETRY_LIM_RST}, rd);
        apb(0, ADDR_SHOT_TMO, 0);
        chk("shot timeout", {16'h0, SHOT_TMO_RST}, rd);
        apb(0, 8'h18, 0);
        chk("unmapped err", 1, err);
    endtask
    // ct, link, rail and temperature causes in turn, cleared by plc or pushbutton reset
    task automatic t_hard();
        i_plc_ctrl <= 16'h0001;
        repeat (8) @(posedge i_clk);
        chk("hv enable", 1, o_hv_enable_req);
        chk("led2", LED_GREEN, o_led2);
        for (int k = 0; k < 4; k++)
        begin
            {i_temp_trip, i_rail_fail, i_link_lost, i_ct_trip} <= 13'h1 << sh[k];
            repeat (6) @(posedge i_clk);
            chk("hard hv enable", 0, o_hv_enable_req);
            chk("led3", LED_RED, o_led3);
            {i_temp_trip, i_rail_fail, i_link_lost, i_ct_trip} <= 13'h0;
            repeat (6) @(posedge i_clk);
            chk("held", 0, o_hv_enable_req);
            i_pb_reset <= k[0];
            i_plc_ctrl[PLC_RESET] <= !k[0];
            repeat (3) @(posedge i_clk);
            {i_pb_reset, i_plc_ctrl[PLC_RESET]} <= 2'b00;
            repeat (6) @(posedge i_clk);
            chk("cleared", 1, o_hv_enable_req);
        end
    endtask
    // armed refusal, three soft faults up to the retry limit, then a shot
    task automatic t_arm();
        {i_acs_hv_req, i_acs_rf_req} <= 2'b11;
        i_plc_ctrl <= 16'h001f;
        apb(1, ADDR_SOFT_DLY, 32'h2);
        apb(1, ADDR_CTRL, 32'h1 << CTRL_ARM);
        apb(0, ADDR_STAT_LO, 0);
        chk("armed", 1, rd[6]);
        apb(0, ADDR_RETRY_LIM, 0);
        chk("refused", 1, err);
        chk("permit", 1, o_rf_permissive);
        chk("hv on", 1, o_hv_on_req);
        for (int n = 1; n <= 3; n++)
        begin
            i_soft_src <= 8'h04;
            repeat (4) @(posedge i_clk);
            i_soft_src <= 8'h00;
            repeat (2) @(posedge i_clk);
            chk("soft permit", 0, o_rf_permissive);
            chk("led4", LED_RED, o_led4);
            repeat (30) @(posedge i_clk);
            chk("attempts", n, o_plc_status_hi[11:4]);
        end
        chk("limit", 1, o_plc_status_lo[8]);
        chk("kept enable", 1, o_hv_enable_req);
        chk("hv on off", 0, o_hv_on_req);
        i_shot_start <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_shot_start <= 1'b0;
        repeat (6) @(posedge i_clk);
        chk("disarmed", LED_OFF, o_led1);
    endtask
    task automatic t_tmo();
        apb(1, ADDR_SHOT_TMO, 32'h3);
        apb(1, ADDR_CTRL, 32'h1);
        repeat (50) @(posedge i_clk);
        chk("timeout", LED_OFF, o_led1);
    endtask
    // cycle ceiling against hangs; also runs the shot clock
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        i_shot_clock <= cyc[2];
        if (cyc == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        while (o_hb_ok !== 1'b1)
            @(posedge i_clk);
        chk("hb fibre", 1, o_hb_ok);
        t_regs();
        t_hard();
        t_arm();
        t_tmo();
        print_verdict();
    end
endmodule // tb_top
bind tfi_interlock tfi_chk chk_u (.*);

// ==== test/tfi_interlock_assertions.sv ====
// tfi_interlock_assertions: port checker.
// assumes bypass held low.
`timescale 1ns/1ps
module tfi_chk import tfi_pkg::*; (
    input wire logic i_clk, // logic clock
    input wire logic i_rstn, // sync reset, low
    input wire logic [3:0] i_ct_trip, // overcurrent pins
    input wire logic [7:0] i_soft_src, // soft causes
    input wire logic i_shot_start, // shot pulse
    input wire logic o_hv_enable_req, // hv enable
    input wire logic o_hv_on_req, // hv on
    input wire logic o_rf_permissive, // rf permit
    input wire logic [3:0] o_pin_sw, // pin switches
    input wire logic o_hb_ok, // heartbeat health
    input wire logic o_event_start, // timer start
    input wire logic o_shot_start_echo, // panel echo
    input wire logic [1:0] o_led1, // armed led
    input wire logic [1:0] o_led2, // hv enable led
    input wire logic [1:0] o_led3 // hv on led
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // outcome of a hard and a soft fault a few cycles after the pin
    sequence s_hard_off;
        !o_hv_enable_req && o_led3 == LED_RED;
    endsequence
    sequence s_rf_off;
        !o_rf_permissive && o_pin_sw == 4'h0;
    endsequence
    a_hard_drops_enable:
    assert property ($rose(|i_ct_trip) |-> ##[2:6] s_hard_off)
        else $error("hv enable kept after overcurrent");
    a_soft_drops_rf:
    assert property ($rose(|i_soft_src) |-> ##[2:6] s_rf_off)
        else $error("rf kept after soft fault");
    // the led register may trail the armed state by one cycle
    a_permit_needs_arm:
    assert property (o_rf_permissive |-> o_led1 == LED_GREEN
        || $past(o_led1) == LED_GREEN)
        else $error("rf permit while not armed");
    a_hv_on_arm:
    assert property (o_hv_on_req |-> o_led1 == LED_GREEN
        || $past(o_led1) == LED_GREEN)
        else $error("hv on while not armed");
    a_leds_never_red:
    assert property (o_led1 != LED_RED && o_led2 != LED_RED)
        else $error("led one or two shows red");
    a_echo_delay:
    assert property (o_shot_start_echo == $past(i_shot_start, 3))
        else $error("shot start echo wrong");
    a_event_single:
    assert property (o_event_start |-> $past(i_shot_start, 3)
        ##1 !o_event_start)
        else $error("event start not a single pulse");
    a_hb_gates_enable:
    assert property (!o_hb_ok [*3] |-> !o_hv_enable_req)
        else $error("hv enable without heartbeat");
endmodule // tfi_chk

// ==== test/tfi_plant_model.sv ====
// tfi_plant_model: chain stages, sync box echo.
// assumes registered request levels.
`timescale 1ns/1ps
module tfi_plant_model (
    input wire logic i_clk, // logic clock
    input wire logic i_heartbeat, // chain input
    input wire logic i_hv_enable_req, // hv enable request
    input wire logic i_rf_group_req, // rf group request
    output logic o_hb_return, // chain output
    output logic o_hv_en_echo = 1'b0, // sync box hv echo
    output logic o_rf_on_echo = 1'b0 // sync box rf echo
);
    logic [2:0] chain_reg = 3'h0;
    // each stage relays a cycle later; a stalled stage would freeze it
    always_ff @(posedge i_clk)
    begin
        chain_reg <= {chain_reg[1:0], i_heartbeat};
        o_hv_en_echo <= i_hv_enable_req;
        o_rf_on_echo <= i_rf_group_req;
    end
    assign o_hb_return = chain_reg[2];
endmodule // tfi_plant_model
